//--- rtl/scri_core.sv
// Purpose: routing class, parity integrity and head-of-buffer timeout
//   for a three-port switch core (port 0 upstream, 1 and 2 downstream)
// Assumes: all strobes come from logic on sys_clk; registers on APB
// Notes: one error message per cycle, lowest port wins
// Functional notes
// - route addresses in 32-bit and 64-bit format
// - ID routing by bus number only
// - memory, I/O, address messages follow address
// - config, completions, ID messages follow ID
// - gathered routing only for PME_TO_Ack
// - broadcast accepted only on upstream port
// - ingress checks LCRC, computes doubleword parity
// - LCRC error triggers link retry
// - altered TLPs get parity updated, not regenerated
// - egress checks parity beside LCRC
// - egress parity error: invert LCRC, end EDB
// - parity error: message if enabled, count
// - downstream sets primary, upstream secondary flag
// - no parity messages once counter saturates
// - silent bit stops messages and flag
// - reset clears silent parity control
// - nullified TLPs carry no parity check
// - produced TLPs get parity, consumed checked
// - discard heads older than 50 ms
// - posted timeout discard sends message
// - per-class drop counters, saturating, clear-on-read
// - posted messages stop on saturation or silence
// - three input classes per port, timestamped
`timescale 1ns/1ps
`include "scri_defines.svh"
module scri_core
#(
  parameter logic [15:0] MS_CYCLES = 16'(`SCRI_MS_CYCLES)
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // route lookup
  input wire logic rt_valid,
  input wire logic [1:0] rt_port,
  input wire logic [2:0] rt_fmt,
  input wire logic [4:0] rt_type,
  input wire logic [63:0] rt_addr,
  input wire logic [7:0] rt_bus,
  input wire logic [7:0] rt_msg_code,
  output logic rt_done,
  output logic [2:0] rt_dest,
  output logic rt_local,
  output logic rt_ur,
  // ingress data link
  input wire logic ing_valid,
  input wire logic [1:0] ing_port,
  input wire logic [31:0] ing_dw,
  input wire logic ing_last,
  input wire logic ing_lcrc_ok,
  output logic ing_par_valid,
  output logic ing_par,
  output logic [2:0] retry_req,
  // in-transit modification
  input wire logic alt_valid,
  input wire logic [31:0] alt_old_dw,
  input wire logic [31:0] alt_new_dw,
  input wire logic alt_old_par,
  output logic alt_par_valid,
  output logic alt_par,
  // switch-produced tlp
  input wire logic gen_valid,
  input wire logic [31:0] gen_dw,
  output logic gen_par_valid,
  output logic gen_par,
  // egress data link
  input wire logic egr_valid,
  input wire logic [1:0] egr_port,
  input wire logic [31:0] egr_dw,
  input wire logic egr_par,
  input wire logic egr_last,
  input wire logic egr_nullified,
  input wire logic [31:0] egr_lcrc,
  output logic egr_end,
  output logic egr_edb,
  output logic [31:0] egr_lcrc_out,
  // switch-consumed tlp
  input wire logic con_valid,
  input wire logic [1:0] con_port,
  input wire logic [31:0] con_dw,
  input wire logic con_par,
  input wire logic con_last,
  output logic con_discard,
  // head of input buffer
  input wire logic hob_valid,
  input wire logic [1:0] hob_port,
  input wire logic [1:0] hob_class,
  input wire logic [15:0] hob_stamp,
  output logic [15:0] ts_now,
  output logic hob_discard,
  // error message request
  output logic err_msg,
  output logic [1:0] err_port
);
  scri_pkg::scri_state_t st;
  scri_pkg::scri_state_t next_st;
  logic [4:0][31:0] lane_dw;
  logic [4:0] lane_base;
  logic [4:0] lane_par;
  logic [2:0][3:0] cnt_inc;
  logic [2:0][3:0] cnt_clr;
  logic [2:0][3:0] cnt_full;
  logic [2:0][3:0][7:0] cnt_val;
  logic [2:0] pe_ev;
  logic [2:0][2:0] to_ev;
  logic [2:0] msg_ev;
  logic apb_go;
  logic apb_wr;
  logic [1:0] a_port;
  logic [3:0] a_idx;
  logic expired;
  logic eg_perr;
  logic is_msg;
  logic [31:0] addr_key;
  logic key_ok;
  logic [1:0] ahit;
  logic [1:0] ihit;

  function automatic logic reg_sel(input logic [11:0] a,
    input logic [1:0] p, input logic [3:0] i);
    return a[11:8] == 4'h0 && a[7:6] == p && a[5:2] == i;
  endfunction

  // {ur, dest}: own window first, else upward, else no route
  function automatic logic [3:0] route_pick(input logic [1:0] hit,
    input logic [1:0] src);
    if (hit[0])
      return 4'h2;
    else if (hit[1])
      return 4'h4;
    else if (src != 2'h0)
      return 4'h1;
    else
      return 4'h8;
  endfunction

  // doubleword parity: ingress, alter, produce, egress, consume
  assign lane_dw[0] = ing_dw;
  assign lane_base[0] = 1'b0;
  assign lane_dw[1] = alt_old_dw ^ alt_new_dw;
  assign lane_base[1] = alt_old_par;
  assign lane_dw[2] = gen_dw;
  assign lane_base[2] = 1'b0;
  assign lane_dw[3] = egr_dw;
  assign lane_base[3] = egr_par;
  assign lane_dw[4] = con_dw;
  assign lane_base[4] = con_par;

  genvar g;
  genvar k;
  generate
    for (g = 0; g < 5; g++)
    begin : g_lane
      scri_parity u_par (
        .dw(lane_dw[g]),
        .base(lane_base[g]),
        .par(lane_par[g])
      );
    end
    // per port: parity count, then posted, nonposted, completion drops
    for (g = 0; g < 3; g++)
    begin : g_port
      assign cnt_inc[g][0] = pe_ev[g];
      assign cnt_clr[g][0] = apb_wr
        && reg_sel(paddr, 2'(g), `SCRI_IDX_PECNT);
      for (k = 1; k < 4; k++)
      begin : g_cls
        assign cnt_inc[g][k] = to_ev[g][k-1];
        assign cnt_clr[g][k] = apb_go && !pwrite
          && reg_sel(paddr, 2'(g), `SCRI_IDX_TDCNT);
      end
      for (k = 0; k < 4; k++)
      begin : g_cnt
        scri_sat_cnt u_cnt (
          .sys_clk(sys_clk),
          .rst(rst),
          .inc(cnt_inc[g][k]),
          .clr(cnt_clr[g][k]),
          .cnt(cnt_val[g][k]),
          .full(cnt_full[g][k])
        );
      end
      assign pe_ev[g] = (eg_perr && egr_port == 2'(g))
        || (con_valid && con_last && con_port == 2'(g)
        && (st.con_err || lane_par[4]));
      for (k = 0; k < 3; k++)
      begin : g_to
        assign to_ev[g][k] = hob_valid && expired
          && hob_port == 2'(g) && hob_class == 2'(k);
      end
      assign msg_ev[g] = (pe_ev[g] && !st.sil_par[g]
        && !cnt_full[g][0])
        || (to_ev[g][scri_pkg::cls_posted] && !st.sil_pto[g]
        && !cnt_full[g][1]);
    end
  endgenerate

  assign apb_go = psel && penable && !st.pready;
  assign apb_wr = psel && penable && st.pready && pwrite;
  assign a_port = paddr[7:6];
  assign a_idx = paddr[5:2];
  // wraps with the 16-bit timestamp, so heads must leave within 65 s
  assign expired = 16'(st.ts_now - hob_stamp) > `SCRI_TIMEOUT_MS;
  // nullified packets are skipped: their parity means nothing
  assign eg_perr = egr_valid && egr_last && !egr_nullified
    && (st.eg_err || lane_par[3]);
  assign is_msg = rt_type[4:3] == 2'h2;
  // 64-bit window compare on bits 47:16; higher bits must be zero
  assign addr_key = rt_fmt[0] ? rt_addr[47:16]
    : {16'h0000, rt_addr[31:16]};
  assign key_ok = !rt_fmt[0] || rt_addr[63:48] == 16'h0000;
  always_comb
  begin
    for (int w = 0; w < 2; w++)
    begin
      ahit[w] = key_ok && addr_key >= st.win_base[w]
        && addr_key <= st.win_limit[w];
      ihit[w] = rt_bus >= st.bus_rng[w][7:0]
        && rt_bus <= st.bus_rng[w][15:8];
    end
  end

  always_comb
  begin
    next_st = st;
    // apb: answer one cycle after access starts, write on completion
    next_st.pready = apb_go;
    next_st.pslverr = 1'b0;
    if (apb_go)
    begin
      next_st.prdata = 32'h0000_0000;
      next_st.pslverr = a_port == 2'h3 || paddr[11:8] != 4'h0
        || a_idx > `SCRI_IDX_BUS;
      if (a_port != 2'h3)
      begin
        case (a_idx)
          `SCRI_IDX_CTL:
            next_st.prdata[1:0] = {st.sil_pto[a_port],
              st.sil_par[a_port]};
          `SCRI_IDX_PECNT:
            next_st.prdata[7:0] = cnt_val[a_port][0];
          `SCRI_IDX_TDCNT:
            next_st.prdata[23:0] = {cnt_val[a_port][3],
              cnt_val[a_port][2], cnt_val[a_port][1]};
          `SCRI_IDX_PSTS:
            next_st.prdata[`SCRI_DPE_BIT] = st.pri_dpe[a_port];
          `SCRI_IDX_SSTS:
            next_st.prdata[`SCRI_DPE_BIT] = st.sec_dpe[a_port];
          `SCRI_IDX_WBASE:
            if (a_port != 2'h0)
              next_st.prdata = st.win_base[a_port[1]];
          `SCRI_IDX_WLIM:
            if (a_port != 2'h0)
              next_st.prdata = st.win_limit[a_port[1]];
          `SCRI_IDX_BUS:
            if (a_port != 2'h0)
              next_st.prdata[15:0] = st.bus_rng[a_port[1]];
          default:
            next_st.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (apb_wr && a_port != 2'h3 && paddr[11:8] == 4'h0)
    begin
      case (a_idx)
        `SCRI_IDX_CTL:
        begin
          next_st.sil_par[a_port] = pwdata[`SCRI_SIL_PAR_BIT];
          next_st.sil_pto[a_port] = pwdata[`SCRI_SIL_PTO_BIT];
        end
        `SCRI_IDX_PSTS:
          if (pwdata[`SCRI_DPE_BIT])
            next_st.pri_dpe[a_port] = 1'b0;
        `SCRI_IDX_SSTS:
          if (pwdata[`SCRI_DPE_BIT])
            next_st.sec_dpe[a_port] = 1'b0;
        `SCRI_IDX_WBASE:
          if (a_port != 2'h0)
            next_st.win_base[a_port[1]] = pwdata;
        `SCRI_IDX_WLIM:
          if (a_port != 2'h0)
            next_st.win_limit[a_port[1]] = pwdata;
        `SCRI_IDX_BUS:
          if (a_port != 2'h0)
            next_st.bus_rng[a_port[1]] = pwdata[15:0];
        default:
          next_st.pslverr = 1'b0;
      endcase
    end
    // flag sets come after the clears so a coincident event wins
    for (int p = 0; p < 3; p++)
    begin
      if (pe_ev[p] && !st.sil_par[p])
      begin
        if (p == 0)
          next_st.sec_dpe[p] = 1'b1;
        else
          next_st.pri_dpe[p] = 1'b1;
      end
    end
    // route classification
    next_st.rt_done = rt_valid;
    next_st.rt_dest = 3'h0;
    next_st.rt_local = 1'b0;
    next_st.rt_ur = 1'b0;
    if (rt_valid)
    begin
      if (rt_port == 2'h3)
        next_st.rt_ur = 1'b1;
      else if ((!is_msg && (rt_type == `SCRI_TY_MRD
        || rt_type == `SCRI_TY_MRDLK || rt_type == `SCRI_TY_IO))
        || (is_msg && rt_type[2:0] == `SCRI_MR_ADDR))
        {next_st.rt_ur, next_st.rt_dest} =
          route_pick(ahit, rt_port);
      else if (rt_type == `SCRI_TY_CFG0 || rt_type == `SCRI_TY_CFG1
        || rt_type == `SCRI_TY_CPL || rt_type == `SCRI_TY_CPLLK
        || (is_msg && rt_type[2:0] == `SCRI_MR_ID))
        {next_st.rt_ur, next_st.rt_dest} =
          route_pick(ihit, rt_port);
      else if (is_msg)
      begin
        case (rt_type[2:0])
          `SCRI_MR_ROOT:
            next_st.rt_dest = 3'h1;
          `SCRI_MR_BCAST:
            if (rt_port == 2'h0)
              next_st.rt_dest = 3'h6;
            else
              next_st.rt_ur = 1'b1;
          `SCRI_MR_LOCAL:
            next_st.rt_local = 1'b1;
          `SCRI_MR_GATHER:
            if (rt_msg_code == `SCRI_PME_TO_ACK)
              next_st.rt_dest = 3'h1;
            else
              next_st.rt_ur = 1'b1;
          default:
            next_st.rt_ur = 1'b1;
        endcase
      end
      else
        next_st.rt_ur = 1'b1;
    end
    // ingress, alter and produce parity, retry on bad lcrc
    next_st.ing_par_valid = ing_valid;
    next_st.ing_par = lane_par[0];
    next_st.retry_req = 3'h0;
    if (ing_valid && ing_last && !ing_lcrc_ok && ing_port != 2'h3)
      next_st.retry_req[ing_port] = 1'b1;
    next_st.alt_par_valid = alt_valid;
    next_st.alt_par = lane_par[1];
    next_st.gen_par_valid = gen_valid;
    next_st.gen_par = lane_par[2];
    // egress packet tracking
    next_st.egr_end = 1'b0;
    next_st.egr_edb = 1'b0;
    if (egr_valid)
    begin
      case (st.eg_state)
        // cleared on the last dword: no carry into the next packet
        scri_pkg::eg_idle:
          next_st.eg_err = !egr_last && lane_par[3];
        scri_pkg::eg_body:
          next_st.eg_err = !egr_last && (st.eg_err || lane_par[3]);
        default:
          next_st.eg_err = 1'b0;
      endcase
      next_st.eg_state = egr_last ? scri_pkg::eg_idle
        : scri_pkg::eg_body;
      if (egr_last)
      begin
        next_st.egr_end = 1'b1;
        next_st.egr_edb = egr_nullified || eg_perr;
        next_st.egr_lcrc_out = eg_perr ? ~egr_lcrc : egr_lcrc;
      end
    end
    // consumed packets: discard on any bad doubleword
    next_st.con_discard = 1'b0;
    if (con_valid)
    begin
      next_st.con_err = !con_last && (st.con_err || lane_par[4]);
      next_st.con_discard = con_last && (st.con_err || lane_par[4]);
    end
    // millisecond timestamp and head-of-buffer age check
    if (st.ms_div == MS_CYCLES - 16'h0001)
    begin
      next_st.ms_div = 16'h0000;
      next_st.ts_now = st.ts_now + 16'h0001;
    end
    else
      next_st.ms_div = st.ms_div + 16'h0001;
    next_st.hob_discard = hob_valid && expired;
    // error messages collapse: one per cycle
    next_st.err_msg = |msg_ev;
    next_st.err_port = msg_ev[0] ? 2'h0 : (msg_ev[1] ? 2'h1 : 2'h2);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.sil_par <= {3{1'(`SCRI_RST_CTL >> `SCRI_SIL_PAR_BIT)}};
      st.sil_pto <= {3{1'(`SCRI_RST_CTL >> `SCRI_SIL_PTO_BIT)}};
      st.win_base <= {2{`SCRI_RST_WIN}};
      st.win_limit <= {2{`SCRI_RST_WIN}};
      st.bus_rng <= {2{`SCRI_RST_BUS}};
      st.eg_state <= scri_pkg::eg_idle;
    end
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign rt_done = st.rt_done;
  assign rt_dest = st.rt_dest;
  assign rt_local = st.rt_local;
  assign rt_ur = st.rt_ur;
  assign ing_par_valid = st.ing_par_valid;
  assign ing_par = st.ing_par;
  assign retry_req = st.retry_req;
  assign alt_par_valid = st.alt_par_valid;
  assign alt_par = st.alt_par;
  assign gen_par_valid = st.gen_par_valid;
  assign gen_par = st.gen_par;
  assign egr_end = st.egr_end;
  assign egr_edb = st.egr_edb;
  assign egr_lcrc_out = st.egr_lcrc_out;
  assign con_discard = st.con_discard;
  assign ts_now = st.ts_now;
  assign hob_discard = st.hob_discard;
  assign err_msg = st.err_msg;
  assign err_port = st.err_port;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_bcast_ur;
    rt_valid && is_msg && rt_type[2:0] == `SCRI_MR_BCAST
      && rt_port != 2'h0 |=> rt_ur && rt_dest == 3'h0;
  endproperty
  a_bcast_ur: assert property (p_bcast_ur)
    else $error("broadcast off upstream not refused");

  property p_gather;
    rt_valid && is_msg && rt_type[2:0] == `SCRI_MR_GATHER
      && rt_port != 2'h3 |=> rt_ur == ($past(rt_msg_code) != 8'h1B);
  endproperty
  a_gather: assert property (p_gather)
    else $error("gathered routing wrong for message code");

  property p_nullify;
    eg_perr |=> egr_edb && egr_lcrc_out == ~$past(egr_lcrc);
  endproperty
  a_nullify: assert property (p_nullify)
    else $error("egress parity error not nullified");

  property p_silent_flag;
    pe_ev[1] && st.sil_par[1] && !st.pri_dpe[1] |=> !st.pri_dpe[1];
  endproperty
  a_silent_flag: assert property (p_silent_flag)
    else $error("silent parity still set the flag");

  property p_down_flag;
    pe_ev[1] && !st.sil_par[1] |=> st.pri_dpe[1] && $stable(st.sec_dpe[1]);
  endproperty
  a_down_flag: assert property (p_down_flag)
    else $error("downstream parity flag not in primary status");

  property p_timeout;
    hob_valid && 16'(st.ts_now - hob_stamp) > 16'h0032
      |=> hob_discard ##1 !hob_discard || $past(hob_valid);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("stale head not discarded");

  property p_retry;
    ing_valid && ing_last && !ing_lcrc_ok && ing_port == 2'h2
      |=> retry_req == 3'h4;
  endproperty
  a_retry: assert property (p_retry)
    else $error("lcrc error did not request retry");

  property p_par_msg;
    pe_ev[2] && !st.sil_par[2] && !cnt_full[2][0] |=> err_msg;
  endproperty
  a_par_msg: assert property (p_par_msg)
    else $error("parity error message missing");

  property p_sat_quiet;
    cnt_full[2][0] && pe_ev[2] && !pe_ev[0] && !pe_ev[1]
      && to_ev == '0 |=> !err_msg;
  endproperty
  a_sat_quiet: assert property (p_sat_quiet)
    else $error("message sent after counter saturated");
endmodule

//--- rtl/scri_defines.svh
// Purpose: constants of the routing and integrity core
// Assumes: included by bare name
// Notes: byte address = port * 0x40 + index * 4
`ifndef SCRI_DEFINES_SVH
`define SCRI_DEFINES_SVH
`define SCRI_CLK_HZ 25000000
`define SCRI_MS_CYCLES (`SCRI_CLK_HZ / 1000)
// 50 ms age limit, in ms
`define SCRI_TIMEOUT_MS 16'h0032
`define SCRI_IDX_CTL 4'h0
`define SCRI_IDX_PECNT 4'h1
`define SCRI_IDX_TDCNT 4'h2
`define SCRI_IDX_PSTS 4'h3
`define SCRI_IDX_SSTS 4'h4
`define SCRI_IDX_WBASE 4'h5
`define SCRI_IDX_WLIM 4'h6
`define SCRI_IDX_BUS 4'h7
`define SCRI_SIL_PAR_BIT 0
`define SCRI_SIL_PTO_BIT 1
`define SCRI_DPE_BIT 15
`define SCRI_RST_CTL 2'h0
`define SCRI_RST_WIN 32'h0000_0000
`define SCRI_RST_BUS 16'h0000
`define SCRI_CNT_MAX 8'hFF
`define SCRI_TY_MRD 5'h00
`define SCRI_TY_MRDLK 5'h01
`define SCRI_TY_IO 5'h02
`define SCRI_TY_CFG0 5'h04
`define SCRI_TY_CFG1 5'h05
`define SCRI_TY_CPL 5'h0A
`define SCRI_TY_CPLLK 5'h0B
`define SCRI_MR_ROOT 3'h0
`define SCRI_MR_ADDR 3'h1
`define SCRI_MR_ID 3'h2
`define SCRI_MR_BCAST 3'h3
`define SCRI_MR_LOCAL 3'h4
`define SCRI_MR_GATHER 3'h5
`define SCRI_PME_TO_ACK 8'h1B
`endif

//--- rtl/scri_pkg.sv
// Purpose: types of the routing and integrity core
// Assumes: nothing
// Notes: all module state is kept in the structs below
package scri_pkg;
  typedef enum logic [1:0] {
    eg_idle = 2'h0,
    eg_body = 2'h1
  } scri_eg_state_t;
  typedef enum logic [1:0] {
    cls_posted = 2'h0,
    cls_nonposted = 2'h1,
    cls_cpl = 2'h2
  } scri_cls_t;
  typedef struct packed {
    logic [7:0] cnt;
  } scri_cnt_st_t;
  typedef struct packed {
    logic [2:0] sil_par;
    logic [2:0] sil_pto;
    logic [2:0] pri_dpe;
    logic [2:0] sec_dpe;
    logic [1:0][31:0] win_base;
    logic [1:0][31:0] win_limit;
    logic [1:0][15:0] bus_rng;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rt_done;
    logic [2:0] rt_dest;
    logic rt_local;
    logic rt_ur;
    logic ing_par_valid;
    logic ing_par;
    logic [2:0] retry_req;
    logic alt_par_valid;
    logic alt_par;
    logic gen_par_valid;
    logic gen_par;
    scri_eg_state_t eg_state;
    logic eg_err;
    logic egr_end;
    logic egr_edb;
    logic [31:0] egr_lcrc_out;
    logic con_err;
    logic con_discard;
    logic [15:0] ms_div;
    logic [15:0] ts_now;
    logic hob_discard;
    logic err_msg;
    logic [1:0] err_port;
  } scri_state_t;
endpackage

//--- rtl/scri_parity.sv
// Purpose: even parity of one doubleword folded into a base bit
// Assumes: combinational use only
// Notes: base 0 gives fresh parity, base = carried parity gives a
//   check (1 = error) or, with dw = old ^ new, an incremental update
`timescale 1ns/1ps
module scri_parity
(
  // data
  input wire logic [31:0] dw,
  input wire logic base,
  // result
  output logic par
);
  assign par = base ^ (^dw);
endmodule

//--- rtl/scri_sat_cnt.sv
// Purpose: 8-bit saturating event counter with clear
// Assumes: inc and clr from logic on sys_clk
// Notes: an increment in the clear cycle is kept
`timescale 1ns/1ps
`include "scri_defines.svh"
module scri_sat_cnt
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic inc,
  input wire logic clr,
  // state
  output logic [7:0] cnt,
  output logic full
);
  scri_pkg::scri_cnt_st_t st;
  scri_pkg::scri_cnt_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (clr)
    begin
      // read-back already took the old value; keep this event
      next_st.cnt = inc ? 8'h01 : 8'h00;
    end
    else if (inc && st.cnt != `SCRI_CNT_MAX)
    begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign cnt = st.cnt;
  assign full = (st.cnt == `SCRI_CNT_MAX);
endmodule

//--- test/scri_link_partner.sv
// Purpose: link partner feeding one-dword tlps into ingress port 2
// Assumes: go is a one-cycle pulse
// Notes: the first copy has a bad lcrc, so a replay must be asked for
`timescale 1ns/1ps
module scri_link_partner
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic go,
  input wire logic [2:0] retry_req,
  // ingress
  output logic ing_valid,
  output logic [1:0] ing_port,
  output logic [31:0] ing_dw,
  output logic ing_last,
  output logic ing_lcrc_ok,
  output logic [1:0] tries
);
  logic send;
  assign send = go | retry_req[2];
  assign ing_port = 2'h2;
  assign ing_last = ing_valid;
  assign ing_lcrc_ok = (tries == 2'h2);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ing_valid <= 1'b0;
      ing_dw <= 32'h0;
      tries <= 2'h0;
    end
    else
    begin
      ing_valid <= send;
      // idle data toggles so a stale word never looks valid
      ing_dw <= send ? 32'h0000_0007 : ~ing_dw;
      tries <= tries + {1'b0, send};
    end
  end
endmodule

//--- test/tb.sv
// Purpose: self-checking bench of the routing and integrity core
// Assumes: ms tick cut to 4 clocks; outputs read at the edge
// Notes: stale-head scenario runs first, while the ms count is small
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er, go, rt_valid;
  logic rt_done, rt_local, rt_ur, ing_valid, ing_last, ing_lcrc_ok, ing_par;
  logic ing_par_valid, alt_valid, alt_old_par, alt_par_valid, alt_par;
  logic gen_valid, gen_par_valid, gen_par, egr_valid, egr_par, egr_last;
  logic egr_nullified, egr_end, egr_edb, con_valid, con_par, con_last;
  logic con_discard, hob_valid, hob_discard, err_msg;
  logic [1:0] rt_port, ing_port, egr_port, con_port, hob_port, hob_class;
  logic [1:0] err_port, mport, tries;
  logic [2:0] rt_fmt, rt_dest, retry_req;
  logic [4:0] rt_type;
  logic [7:0] rt_bus, rt_msg_code;
  logic [11:0] paddr;
  logic [15:0] hob_stamp, ts_now;
  logic [31:0] pwdata, prdata, ing_dw, alt_old_dw, alt_new_dw, gen_dw, egr_dw;
  logic [31:0] egr_lcrc, egr_lcrc_out, con_dw, rd;
  logic [63:0] rt_addr;
  int n_fail = 0, n_tests = 0, msgs = 0, npar = 0;
  scri_core #(.MS_CYCLES(16'h0004)) dut (.*);
  scri_link_partner lp (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (err_msg === 1'b1)
    begin
      msgs <= msgs + 1;
      mport <= err_port;
    end
    if (ing_par_valid === 1'b1 && ing_par === 1'b1)
      npar <= npar + 1;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input string n, input logic [39:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (k >= 20)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp("register", {8'h0, e}, {8'h0, rd});
  endtask
  task msg(input int n, input logic [1:0] p);
    cmp("message", {22'h0, n[15:0], p}, {22'h0, msgs[15:0], mport});
  endtask
  task rt(input logic [1:0] p, input logic [4:0] t, input logic [63:0] a,
          input logic [7:0] b, input logic [5:0] e);
    {rt_valid, rt_port, rt_type, rt_addr} <= {1'b1, p, t, a};
    {rt_fmt, rt_bus, rt_msg_code} <= {2'h0, |a[63:32], b, b};
    @(posedge sys_clk);
    rt_valid <= 1'b0;
    @(posedge sys_clk);
    cmp("route", {34'h0, e}, {34'h0, rt_done, rt_dest, rt_local, rt_ur});
  endtask
  task egr(input logic [1:0] p, input logic n, b);
    {egr_valid, egr_port, egr_nullified, egr_last} <= {1'b1, p, n, 1'b0};
    {egr_dw, egr_par} <= {32'h0000_0001, 1'b1};
    @(posedge sys_clk);
    {egr_dw, egr_par, egr_last} <= {32'h0000_0003, b, 1'b1};
    @(posedge sys_clk);
    egr_valid <= 1'b0;
    @(posedge sys_clk);
    cmp("egress", {7'h1, n | b, (b & ~n) ? ~egr_lcrc : egr_lcrc},
        {6'h0, egr_end, egr_edb, egr_lcrc_out});
  endtask
  task t_stale;
    int k;
    for (k = 0; ts_now !== 16'h0033 && k < 400; k++)
      @(posedge sys_clk);
    if (k >= 400)
    begin
      n_fail++;
      tally_and_finish;
    end
    {hob_valid, hob_port, hob_stamp} <= {1'b1, 2'h1, 16'h0001};
    @(posedge sys_clk);
    hob_stamp <= 16'h0000;
    @(posedge sys_clk);
    {hob_port, hob_class} <= 4'h9;
    cmp("stale", 40'h0, {39'h0, hob_discard});
    @(posedge sys_clk);
    hob_valid <= 1'b0;
    cmp("stale", 40'h1, {39'h0, hob_discard});
    @(posedge sys_clk);
    cmp("stale", 40'h1, {39'h0, hob_discard});
    rdc(12'h048, 32'h1);
    rdc(12'h048, 32'h0);
    rdc(12'h088, 32'h100);
    msg(1, 2'h1);
    apb(1'b1, 12'h040, 32'h2);
    {hob_valid, hob_port, hob_class} <= 5'h14;
    @(posedge sys_clk);
    hob_valid <= 1'b0;
    rdc(12'h048, 32'h1);
    msg(1, 2'h1);
  endtask
  task t_route;
    apb(1'b1, 12'h054, 32'h1);
    apb(1'b1, 12'h058, 32'h1);
    apb(1'b1, 12'h09C, 32'h0505);
    rt(2'h0, 5'h00, 64'h1_0000, 8'h00, 6'h28);
    rt(2'h0, 5'h00, 64'h1_0000_0001_0000, 8'h00, 6'h21);
    rt(2'h1, 5'h02, 64'hFFFF_0000, 8'h00, 6'h24);
    rt(2'h0, 5'h05, 64'h0, 8'h05, 6'h30);
    rt(2'h1, 5'h10, 64'h0, 8'h00, 6'h24);
    rt(2'h0, 5'h13, 64'h0, 8'h00, 6'h38);
    rt(2'h2, 5'h13, 64'h0, 8'h00, 6'h21);
    rt(2'h1, 5'h14, 64'h0, 8'h00, 6'h22);
    rt(2'h1, 5'h15, 64'h0, 8'h1B, 6'h24);
    rt(2'h1, 5'h15, 64'h0, 8'h19, 6'h21);
    rt(2'h2, 5'h11, 64'h1_0000, 8'h00, 6'h28);
    rt(2'h1, 5'h12, 64'h0, 8'h05, 6'h30);
  endtask
  task t_parity;
    egr(2'h1, 1'b0, 1'b1);
    rdc(12'h044, 32'h1);
    rdc(12'h04C, 32'h8000);
    msg(2, 2'h1);
    egr(2'h1, 1'b1, 1'b1);
    rdc(12'h044, 32'h1);
    apb(1'b1, 12'h04C, 32'h8000);
    apb(1'b1, 12'h040, 32'h1);
    egr(2'h1, 1'b0, 1'b1);
    rdc(12'h044, 32'h2);
    rdc(12'h04C, 32'h0);
    egr(2'h0, 1'b0, 1'b1);
    rdc(12'h010, 32'h8000);
    msg(3, 2'h0);
  endtask
  task t_misc;
    {con_valid, con_port, con_dw, con_last} <= {3'h6, 32'h1, 1'b1};
    {gen_valid, gen_dw, alt_valid} <= {1'b1, 32'h7, 1'b1};
    // stored parity is wrong on purpose: an update must keep it wrong
    {alt_old_dw, alt_new_dw} <= {32'h1, 32'h3};
    @(posedge sys_clk);
    {con_valid, gen_valid, alt_valid} <= 3'h0;
    @(posedge sys_clk);
    cmp("discard", 40'h1, {39'h0, con_discard});
    cmp("parity", 40'hF, {36'h0, gen_par_valid, gen_par, alt_par_valid,
        alt_par});
    rdc(12'h084, 32'h1);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cmp("replay", 40'h2, {38'h0, tries});
    cmp("ingress", 40'h2, {8'h0, npar});
    repeat (254) egr(2'h2, 1'b0, 1'b1);
    rdc(12'h084, 32'hFF);
    msg(258, 2'h2);
    egr(2'h2, 1'b0, 1'b1);
    rdc(12'h084, 32'hFF);
    msg(258, 2'h2);
  endtask
  initial
  begin
    {psel, penable, pwrite, go, rt_valid, alt_valid, alt_old_par, gen_valid,
     egr_valid, egr_par, egr_last, egr_nullified, con_valid, con_par,
     con_last, hob_valid, paddr, pwdata, rt_port, rt_fmt, rt_type, rt_addr,
     rt_bus, rt_msg_code, alt_old_dw, alt_new_dw, gen_dw, egr_port, egr_dw,
     con_port, con_dw, hob_port, hob_class, hob_stamp} = '0;
    rst = 1'b1;
    egr_lcrc = 32'hC3A5_0F96;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(12'h040, 32'h0);
    apb(1'b0, 12'h0C0, 32'h0);
    cmp("slverr", 40'h1, {39'h0, er});
    t_stale;
    t_route;
    t_parity;
    t_misc;
    tally_and_finish;
  end
endmodule
